// *** eirqf_chan.sv ***
`timescale 1ns/1ps
module eirqf_chan (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Sampling ticks
  eirqf_tick_if.snk ticks,
  // Configuration
  input wire logic enable,
  input wire logic slow_mode,
  input wire logic [1:0] edge_sel,
  input wire logic [1:0] rate_sel,
  // Pin
  input wire logic pin,
  // Results
  output logic req_r,
  output logic level_r
);
  logic sync1_r;
  logic sync2_r;
  logic [2:0] smp_r;
  logic filt_r;
  logic filt_nxt;
  wire [2:0] smp_nxt = {smp_r[1:0], sync2_r};
  wire fast_en = (rate_sel == eirqf_pkg::EIRQF_DIV1) ? ticks.gear :
                 (rate_sel == eirqf_pkg::EIRQF_DIV4) ? ticks.div4 :
                 (rate_sel == eirqf_pkg::EIRQF_DIV8) ? ticks.div8 : ticks.div16;
  wire sample_en = slow_mode ? ticks.lf_quarter : fast_en;
  // Three equal samples needed, so a one-sample glitch never passes
  assign filt_nxt = !sample_en ? filt_r : (&smp_nxt) ? 1'b1 : (|smp_nxt) ? filt_r : 1'b0;
  wire hit = enable & eirqf_pkg::eirqf_edge_hit(eirqf_pkg::eirqf_edge_t'(edge_sel),
                                                 filt_r, filt_nxt);

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= pin;
      sync2_r <= sync1_r;
    end
  end

  // ****************************************
  // Noise canceller and edge detect
  // ****************************************
  // Disabled channel has no clock, so its filter is held cleared
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      smp_r <= 3'h0;
      filt_r <= 1'b0;
      req_r <= 1'b0;
      level_r <= 1'b0;
    end else if (!enable) begin
      smp_r <= 3'h0;
      filt_r <= 1'b0;
      req_r <= 1'b0;
      level_r <= 1'b0;
    end else begin
      if (sample_en) begin
        smp_r <= smp_nxt;
      end
      filt_r <= filt_nxt;
      req_r <= hit;
      if (hit) begin
        level_r <= filt_nxt;
      end
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  sequence rose_seq;
    !$past(filt_r) && filt_r;
  endsequence
  sequence fell_seq;
    $past(filt_r) && !filt_r;
  endsequence

  rise_req_a: assert property (@(posedge clk) disable iff (!resetn)
    req_r && $past(edge_sel) == 2'b00 |-> rose_seq)
    else $error("rising request without rising level");
  fall_req_a: assert property (@(posedge clk) disable iff (!resetn)
    req_r && $past(edge_sel) == 2'b01 |-> fell_seq)
    else $error("falling request without falling level");
  both_edge_a: assert property (@(posedge clk) disable iff (!resetn)
    $past(enable) && enable && $past(edge_sel) == 2'b10 && $past(filt_r) != filt_r
    |-> req_r)
    else $error("both-edge mode missed a transition");
  reserved_quiet_a: assert property (@(posedge clk) disable iff (!resetn)
    $past(edge_sel) == 2'b11 |-> !req_r)
    else $error("request under reserved edge code");
  level_capture_a: assert property (@(posedge clk) disable iff (!resetn)
    req_r |-> level_r == filt_r ##1 (req_r || !$past(enable) || level_r == $past(level_r)))
    else $error("captured level wrong or unstable");
endmodule

// *** eirqf_consts.svh ***
`ifndef EIRQF_CONSTS_SVH
`define EIRQF_CONSTS_SVH

// ****************************************
// Clock rates
// ****************************************
`define EIRQF_CLK_HZ 40000000
`define EIRQF_LF_HZ 32768
`define EIRQF_LF_DIV (`EIRQF_CLK_HZ / `EIRQF_LF_HZ)
`define EIRQF_LF_STEPS 4
`define EIRQF_GEAR_DIV 1

// ****************************************
// Register map
// ****************************************
`define EIRQF_ADDR_W 12
`define EIRQF_OFS_CTRL2 12'h0fd9
`define EIRQF_OFS_CTRL3 12'h0fda
`define EIRQF_OFS_STATUS 12'h0fe0
`define EIRQF_OFS_MASK 12'h0fe1

// ****************************************
// Control register fields
// ****************************************
`define EIRQF_LVL_BIT 4
`define EIRQF_ES_MSB 3
`define EIRQF_ES_LSB 2
`define EIRQF_NC_MSB 1
`define EIRQF_NC_LSB 0
`define EIRQF_CFG_MSB 3
`define EIRQF_CFG_RST 4'h0
`define EIRQF_BYTE_RST 8'h00
`define EIRQF_UPPER_ZERO 3'h0
`define EIRQF_FLAG_RST 2'h0

`endif

// *** eirqf_pin_drv.sv ***
`timescale 1ns/1ps
// ****************************************
// Board-side pin source
// ****************************************
module eirqf_pin_drv (
  // Clock
  input wire logic clk,
  // Pins
  output logic pin_ch2,
  output logic pin_ch3
);
  initial begin
    pin_ch2 = 1'b0;
    pin_ch3 = 1'b0;
  end

  // Pins are push-pull, so they only change right after an edge
  task automatic set(input int ch, input logic v);
    @(posedge clk);
    if (ch == 2) begin
      pin_ch2 <= v;
    end else begin
      pin_ch3 <= v;
    end
  endtask

  // High for w cycles: short w models a glitch, long w a real event
  task automatic pulse(input int ch, input int w);
    set(ch, 1'b1);
    repeat (w - 1) @(posedge clk);
    set(ch, 1'b0);
  endtask
endmodule

// *** eirqf_pkg.sv ***
package eirqf_pkg;

  // ****************************************
  // Edge and rate codes
  // ****************************************
  typedef enum logic [1:0] {
    EIRQF_RISE = 2'b00,
    EIRQF_FALL = 2'b01,
    EIRQF_BOTH = 2'b10,
    EIRQF_RSVD = 2'b11
  } eirqf_edge_t;

  typedef enum logic [1:0] {
    EIRQF_DIV1 = 2'b00,
    EIRQF_DIV4 = 2'b01,
    EIRQF_DIV8 = 2'b10,
    EIRQF_DIV16 = 2'b11
  } eirqf_rate_t;

  // Request condition from an old and new filtered level
  function automatic logic eirqf_edge_hit(input eirqf_edge_t sel, input logic old_lvl,
                                          input logic new_lvl);
    logic hit;
    hit = 1'b0;
    case (sel)
      EIRQF_RISE: hit = new_lvl & ~old_lvl;
      EIRQF_FALL: hit = old_lvl & ~new_lvl;
      EIRQF_BOTH: hit = old_lvl ^ new_lvl;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

endpackage

// *** eirqf_rate.sv ***
`timescale 1ns/1ps
`include "eirqf_consts.svh"
module eirqf_rate #(
  parameter int LF_DIV = `EIRQF_LF_DIV,
  parameter int GEAR_DIV = `EIRQF_GEAR_DIV
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Sampling ticks
  eirqf_tick_if.src ticks
);
  logic [15:0] lf_cnt_r;
  logic [15:0] gear_cnt_r;
  logic [3:0] gdiv_r;
  logic [1:0] lq_r;
  wire lf_tick = (lf_cnt_r == 16'(LF_DIV - 1));
  wire gear_tick = (gear_cnt_r == 16'(GEAR_DIV - 1));

  // ****************************************
  // Dividers
  // ****************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lf_cnt_r <= 16'h0000;
      gear_cnt_r <= 16'h0000;
      gdiv_r <= 4'h0;
      lq_r <= 2'h0;
    end else begin
      lf_cnt_r <= lf_tick ? 16'h0000 : lf_cnt_r + 16'h0001;
      gear_cnt_r <= gear_tick ? 16'h0000 : gear_cnt_r + 16'h0001;
      if (gear_tick) begin
        gdiv_r <= gdiv_r + 4'h1;
      end
      if (lf_tick) begin
        lq_r <= lq_r + 2'h1;
      end
    end
  end

  assign ticks.gear = gear_tick;
  assign ticks.div4 = gear_tick & (&gdiv_r[1:0]);
  assign ticks.div8 = gear_tick & (&gdiv_r[2:0]);
  assign ticks.div16 = gear_tick & (&gdiv_r);
  // Quarter of the low-frequency clock serves every slow-mode code
  assign ticks.lf_quarter = lf_tick & (&lq_r);

  // ****************************************
  // Checks
  // ****************************************
  // Cycles since the last slow tick, so the spacing is checked, not the decode
  logic [15:0] q_gap_r;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q_gap_r <= 16'h0000;
    end else begin
      q_gap_r <= ticks.lf_quarter ? 16'h0000 : q_gap_r + 16'h0001;
    end
  end

  quarter_rate_a: assert property (@(posedge clk) disable iff (!resetn)
    ticks.lf_quarter |-> q_gap_r == 16'(`EIRQF_LF_STEPS * LF_DIV - 1))
    else $error("slow sample tick off its quarter spacing");
endmodule

// *** eirqf_tick_if.sv ***
`timescale 1ns/1ps
interface eirqf_tick_if;
  logic gear;
  logic div4;
  logic div8;
  logic div16;
  logic lf_quarter;
  modport src(output gear, output div4, output div8, output div16, output lf_quarter);
  modport snk(input gear, input div4, input div8, input div16, input lf_quarter);
endinterface

// *** eirqf_top.sv ***
`timescale 1ns/1ps
`include "eirqf_consts.svh"
module eirqf_top #(
  parameter int LF_DIV = `EIRQF_LF_DIV,
  parameter int GEAR_DIV = `EIRQF_GEAR_DIV
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Register port
  input wire logic [`EIRQF_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // External pins
  input wire logic pin_ch2,
  input wire logic pin_ch3,
  // System control
  input wire logic [1:0] channel_module_enable,
  input wire logic slow_run_mode,
  // Interrupt outputs
  output logic ch2_irq_req,
  output logic ch3_irq_req,
  output logic irq
);

  // ****************************************
  // Registers and wires
  // ****************************************
  logic [3:0] ctrl2_r;
  logic [3:0] ctrl3_r;
  logic [3:0] ctrl2_nxt;
  logic [3:0] ctrl3_nxt;
  logic [1:0] status_r;
  logic [1:0] status_nxt;
  logic [1:0] mask_r;
  logic [1:0] mask_nxt;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic irq_r;
  logic irq_nxt;
  logic lvl2;
  logic lvl3;
  logic req2;
  logic req3;
  wire en2 = channel_module_enable[0];
  wire en3 = channel_module_enable[1];

  eirqf_tick_if ticks_if();

  // ****************************************
  // Address decode
  // ****************************************
  wire hit_c2 = (reg_addr == `EIRQF_OFS_CTRL2);
  wire hit_c3 = (reg_addr == `EIRQF_OFS_CTRL3);
  wire hit_st = (reg_addr == `EIRQF_OFS_STATUS);
  wire hit_mk = (reg_addr == `EIRQF_OFS_MASK);
  wire wr_c2 = reg_wr & hit_c2 & en2;
  wire wr_c3 = reg_wr & hit_c3 & en3;
  wire wr_mk = reg_wr & hit_mk;
  wire rd_st = reg_rd & hit_st;

  // ****************************************
  // Control registers
  // ****************************************
  // disabled clears
  // Writes while disabled are dropped, the channel has no clock then
  assign ctrl2_nxt = !en2 ? `EIRQF_CFG_RST : wr_c2 ? reg_wdata[`EIRQF_CFG_MSB:0] : ctrl2_r;
  assign ctrl3_nxt = !en3 ? `EIRQF_CFG_RST : wr_c3 ? reg_wdata[`EIRQF_CFG_MSB:0] : ctrl3_r;
  assign mask_nxt = wr_mk ? reg_wdata[1:0] : mask_r;

  // ****************************************
  // Event status
  // ****************************************
  // New request beats the read that clears it
  assign status_nxt = (rd_st ? `EIRQF_FLAG_RST : status_r) | {req3, req2};
  assign irq_nxt = |(status_nxt & mask_nxt);

  // ****************************************
  // Read data
  // ****************************************
  // upper bits zero
  wire [7:0] c2_view = {`EIRQF_UPPER_ZERO, lvl2, ctrl2_r};
  wire [7:0] c3_view = {`EIRQF_UPPER_ZERO, lvl3, ctrl3_r};
  wire [7:0] st_view = {6'h00, status_r};
  wire [7:0] mk_view = {6'h00, mask_r};
  // Unmapped addresses read zero
  assign rdata_nxt = !reg_rd ? `EIRQF_BYTE_RST :
                     hit_c2 ? c2_view :
                     hit_c3 ? c3_view :
                     hit_st ? st_view :
                     hit_mk ? mk_view : `EIRQF_BYTE_RST;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl2_r <= `EIRQF_CFG_RST;
      ctrl3_r <= `EIRQF_CFG_RST;
      mask_r <= `EIRQF_FLAG_RST;
    end else begin
      ctrl2_r <= ctrl2_nxt;
      ctrl3_r <= ctrl3_nxt;
      mask_r <= mask_nxt;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      status_r <= `EIRQF_FLAG_RST;
      irq_r <= 1'b0;
      rdata_r <= `EIRQF_BYTE_RST;
    end else begin
      status_r <= status_nxt;
      irq_r <= irq_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign irq = irq_r;
  assign ch2_irq_req = req2;
  assign ch3_irq_req = req3;

  // ****************************************
  // Rate generator and channels
  // ****************************************
  eirqf_rate #(
    .LF_DIV(LF_DIV),
    .GEAR_DIV(GEAR_DIV)
  ) u_rate (
    .clk(clk),
    .resetn(resetn),
    .ticks(ticks_if.src)
  );

  eirqf_chan u_ch2 (
    .clk(clk),
    .resetn(resetn),
    .ticks(ticks_if.snk),
    .enable(en2),
    .slow_mode(slow_run_mode),
    .edge_sel(ctrl2_r[`EIRQF_ES_MSB:`EIRQF_ES_LSB]),
    .rate_sel(ctrl2_r[`EIRQF_NC_MSB:`EIRQF_NC_LSB]),
    .pin(pin_ch2),
    .req_r(req2),
    .level_r(lvl2)
  );

  eirqf_chan u_ch3 (
    .clk(clk),
    .resetn(resetn),
    .ticks(ticks_if.snk),
    .enable(en3),
    .slow_mode(slow_run_mode),
    .edge_sel(ctrl3_r[`EIRQF_ES_MSB:`EIRQF_ES_LSB]),
    .rate_sel(ctrl3_r[`EIRQF_NC_MSB:`EIRQF_NC_LSB]),
    .pin(pin_ch3),
    .req_r(req3),
    .level_r(lvl3)
  );

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence wr2_seq;
    reg_wr && hit_c2 && en2 ##1 en2;
  endsequence

  ctrl_write_a: assert property (
    wr2_seq |-> ctrl2_r == $past(reg_wdata[3:0]))
    else $error("channel two control write not stored");
  ctrl_read_a: assert property (
    reg_rd && hit_c2 |=> reg_rdata[3:0] == $past(ctrl2_r))
    else $error("channel two control readback wrong");
  upper_zero_a: assert property (
    reg_rd && (hit_c2 || hit_c3) |=> reg_rdata[7:5] == 3'h0)
    else $error("upper control bits not zero");
  level_read_a: assert property (
    reg_rd && hit_c3 |=> reg_rdata[4] == $past(lvl3))
    else $error("level flag readback wrong");
  disable_clear_a: assert property (
    !en2 |=> ctrl2_r == 4'h0 && !req2 && !lvl2)
    else $error("disabled channel kept state");
  sticky_set_a: assert property (
    req2 |=> status_r[0])
    else $error("request not latched in status");
  read_clear_a: assert property (
    rd_st && !req2 && !req3 |=> status_r == 2'h0)
    else $error("status read did not clear");
  irq_level_a: assert property (
    irq == |(status_r & mask_r))
    else $error("interrupt output does not follow status");
  read_once_a: assert property (
    !reg_rd |=> reg_rdata == 8'h00)
    else $error("read data outside read cycle");

  // ****************************************
  // Checks: status and interrupt
  // ****************************************
  // Set beats clear, so a request during the read survives
  keep_on_clear_a: assert property (
    rd_st && req2 |=> status_r[0])
    else $error("request lost under status read");
  status3_keep_a: assert property (
    rd_st && req3 |=> status_r[1])
    else $error("request lost under status read");
  sticky3_set_a: assert property (
    req3 |=> status_r[1])
    else $error("request not latched in status");
  status_hold_a: assert property (
    !rd_st |=> (status_r & $past(status_r)) == $past(status_r))
    else $error("status bit dropped without a read");
  req2_pulse_a: assert property (
    req2 |=> !req2)
    else $error("channel two request longer than one cycle");
  req3_pulse_a: assert property (
    req3 |=> !req3)
    else $error("channel three request longer than one cycle");
  irq2_rise_a: assert property (
    req2 && mask_r[0] && !wr_mk |=> irq)
    else $error("unmasked request did not raise interrupt");
  irq3_rise_a: assert property (
    req3 && mask_r[1] && !wr_mk |=> irq)
    else $error("unmasked request did not raise interrupt");
  irq_clear_a: assert property (
    rd_st && !req2 && !req3 |=> !irq)
    else $error("interrupt stayed high after status read");
  // With the mask clear, no status bit may reach the interrupt line
  irq_low_a: assert property (
    !(|mask_r) && !wr_mk |=> !irq)
    else $error("interrupt high with mask clear");

  // ****************************************
  // Checks: channel three and enables
  // ****************************************
  sequence wr3_seq;
    reg_wr && hit_c3 && en3 ##1 en3;
  endsequence

  ctrl3_write_a: assert property (
    wr3_seq |-> ctrl3_r == $past(reg_wdata[3:0]))
    else $error("channel three control write not stored");
  ctrl3_read_a: assert property (
    reg_rd && hit_c3 |=> reg_rdata[3:0] == $past(ctrl3_r))
    else $error("channel three control readback wrong");
  ctrl2_hold_a: assert property (
    en2 && !wr_c2 |=> ctrl2_r == $past(ctrl2_r))
    else $error("channel two control changed without a write");
  ctrl3_hold_a: assert property (
    en3 && !wr_c3 |=> ctrl3_r == $past(ctrl3_r))
    else $error("channel three control changed without a write");
  disable3_clear_a: assert property (
    !en3 |=> ctrl3_r == 4'h0 && !req3 && !lvl3)
    else $error("disabled channel kept state");
  // Writes to a stopped channel must not appear after a restart
  drop2_write_a: assert property (
    reg_wr && hit_c2 && !en2 |=> ctrl2_r == 4'h0)
    else $error("write to stopped channel two landed");
  drop3_write_a: assert property (
    reg_wr && hit_c3 && !en3 |=> ctrl3_r == 4'h0)
    else $error("write to stopped channel three landed");

  // ****************************************
  // Checks: mask and read port
  // ****************************************
  mask_write_a: assert property (
    wr_mk |=> mask_r == $past(reg_wdata[1:0]))
    else $error("mask write not stored");
  mask_hold_a: assert property (
    !wr_mk |=> mask_r == $past(mask_r))
    else $error("mask changed without a write");
  mask_read_a: assert property (
    reg_rd && hit_mk |=> reg_rdata == {6'h00, $past(mask_r)})
    else $error("mask readback wrong");
  status_read_a: assert property (
    reg_rd && hit_st |=> reg_rdata == {6'h00, $past(status_r)})
    else $error("status readback wrong");
  level2_read_a: assert property (
    reg_rd && hit_c2 |=> reg_rdata[4] == $past(lvl2))
    else $error("level flag readback wrong");
  unmapped_zero_a: assert property (
    reg_rd && !(hit_c2 || hit_c3 || hit_st || hit_mk) |=> reg_rdata == 8'h00)
    else $error("unmapped address read not zero");
endmodule

// *** tb_ext_irq_edge_noise_filter.sv ***
`timescale 1ns/1ps
`include "eirqf_consts.svh"
module tb_ext_irq_edge_noise_filter;
  // ****************************************
  // Bench signals
  // ****************************************
  localparam int LFD = 4;
  localparam logic [11:0] C2 = `EIRQF_OFS_CTRL2;
  localparam logic [11:0] C3 = `EIRQF_OFS_CTRL3;
  localparam logic [11:0] ST = `EIRQF_OFS_STATUS;
  localparam logic [11:0] MK = `EIRQF_OFS_MASK;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic pin_ch2;
  logic pin_ch3;
  logic [1:0] channel_module_enable = 2'b00;
  logic slow_run_mode = 1'b0;
  logic ch2_irq_req;
  logic ch3_irq_req;
  logic irq;
  logic [7:0] cnt2 = 8'h00;
  logic [7:0] cnt3 = 8'h00;
  logic [7:0] b;
  int failures = 0;
  int check_count = 0;

  always #12.5 clk = ~clk;

  always @(posedge clk) begin
    if (ch2_irq_req === 1'b1) cnt2 <= cnt2 + 8'h01;
    if (ch3_irq_req === 1'b1) cnt3 <= cnt3 + 8'h01;
  end

  eirqf_top #(.LF_DIV(LFD), .GEAR_DIV(1)) u_eirqf_top (
    .clk(clk), .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_ch2(pin_ch2),
    .pin_ch3(pin_ch3), .channel_module_enable(channel_module_enable),
    .slow_run_mode(slow_run_mode), .ch2_irq_req(ch2_irq_req),
    .ch3_irq_req(ch3_irq_req), .irq(irq)
  );

  eirqf_pin_drv u_eirqf_pin_drv (.clk(clk), .pin_ch2(pin_ch2), .pin_ch3(pin_ch3));

  // ****************************************
  // Shared tasks
  // ****************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Data stand only in the cycle after the strobe, so sample mid-cycle
  task automatic rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    check(d, exp);
  endtask

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic test_reset();
    rd_chk(C2, 8'h00);
    rd_chk(C3, 8'h00);
    rd_chk(ST, 8'h00);
    rd_chk(12'h0fdb, 8'h00);
    wr(C2, 8'h0f);
    rd_chk(C2, 8'h00);
    check({7'h00, irq}, 8'h00);
    $display("test reset done");
  endtask

  task automatic test_layout();
    @(posedge clk);
    channel_module_enable <= 2'b11;
    wr(C2, 8'hff);
    rd_chk(C2, 8'h0f);
    wr(C3, 8'he6);
    rd_chk(C3, 8'h06);
    wr(C3, 8'h00);
    $display("test layout done");
  endtask

  // Counts and flag per edge code, bit index is the code
  task automatic test_edges();
    logic [3:0] hi_n = 4'b0101;
    logic [3:0] lo_n = 4'b0110;
    logic [3:0] hi_f = 4'b0111;
    logic [3:0] lo_f = 4'b0001;
    for (int c = 0; c < 4; c++) begin
      // Software keeps the mask clear while rewriting
      wr(C2, {4'h0, 2'(c), 2'b00});
      b = cnt2;
      u_eirqf_pin_drv.set(2, 1'b1);
      repeat (10) @(posedge clk);
      check(cnt2 - b, {7'h00, hi_n[c]});
      rd_chk(C2, {3'h0, hi_f[c], 2'(c), 2'b00});
      b = cnt2;
      u_eirqf_pin_drv.set(2, 1'b0);
      repeat (10) @(posedge clk);
      check(cnt2 - b, {7'h00, lo_n[c]});
      rd_chk(C2, {3'h0, lo_f[c], 2'(c), 2'b00});
    end
    $display("test edges done");
  endtask

  // Glitch of two sample periods dropped, five sample periods kept
  task automatic test_rates();
    int n;
    for (int c = 0; c < 4; c++) begin
      n = (c == 0) ? 1 : (1 << (c + 1));
      wr(C3, {6'h00, 2'(c)});
      b = cnt3;
      u_eirqf_pin_drv.pulse(3, 2 * n);
      repeat (8 * n + 6) @(posedge clk);
      check(cnt3 - b, 8'h00);
      u_eirqf_pin_drv.pulse(3, 5 * n);
      repeat (8 * n + 6) @(posedge clk);
      check(cnt3 - b, 8'h01);
    end
    $display("test rates done");
  endtask

  task automatic test_slow();
    wr(C3, 8'h00);
    // Mask stays clear across the mode change
    wr(MK, 8'h00);
    slow_run_mode <= 1'b1;
    repeat (12 * LFD) @(posedge clk);
    rd(ST, b);
    b = cnt3;
    u_eirqf_pin_drv.pulse(3, 8);
    repeat (8 * 4 * LFD) @(posedge clk);
    check(cnt3 - b, 8'h00);
    u_eirqf_pin_drv.pulse(3, 5 * 4 * LFD);
    repeat (8 * 4 * LFD) @(posedge clk);
    check(cnt3 - b, 8'h01);
    slow_run_mode <= 1'b0;
    repeat (2 + 3) @(posedge clk);
    rd(ST, b);
    $display("test slow done");
  endtask

  task automatic test_irq();
    wr(C2, 8'h00);
    wr(MK, 8'h01);
    rd_chk(MK, 8'h01);
    u_eirqf_pin_drv.pulse(3, 6);
    repeat (12) @(posedge clk);
    @(negedge clk);
    check({7'h00, irq}, 8'h00);
    u_eirqf_pin_drv.pulse(2, 6);
    repeat (12) @(posedge clk);
    @(negedge clk);
    check({7'h00, irq}, 8'h01);
    rd_chk(ST, 8'h03);
    check({7'h00, irq}, 8'h00);
    rd_chk(ST, 8'h00);
    // Mask cleared before the rewrite and the enable change
    wr(MK, 8'h00);
    wr(C2, 8'h05);
    rd_chk(C2, 8'h15);
    @(posedge clk);
    channel_module_enable <= 2'b10;
    @(posedge clk);
    channel_module_enable <= 2'b11;
    rd_chk(C2, 8'h00);
    $display("test irq done");
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    test_reset();
    test_layout();
    test_edges();
    test_rates();
    test_slow();
    test_irq();
    tally_and_finish();
  end

  initial begin
    repeat (60000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
endmodule
